// file: hdl/pfcms_top.sv
// pfcms_top: operating mode and switching cycle sequencer of a digital pfc controller
// assumes sense codes come from adcs on another clock and zero-current from a comparator pin
// Behaviour
// R1: startup below 90% link, normal at 100%
// R2: power-up begins in startup mode
// R3: startup on-time gives constant peak current
// R4: startup off-time from conduction boundary
// R5: startup runs critical conduction each cycle
// R6: below 5% power, skip whole half-lines
// R7: adapt frequency to line voltage
// R8: cap frequency at 70 or 100 kHz; startup has no cap and restarts at the first valley
// R9: discontinuous normally, quasi-critical near peak
// R10: falling zcd starts a new cycle
// R11: light load uses on-time modulation
// R12: power estimate assumes full efficiency
// R13: gate low when suppressed or off
`timescale 1ns/1ns
`default_nettype none
module pfcms_top (
	// clock and reset
	input  wire logic                          clk_in,
	input  wire logic                          rst_in,
	// variant strap
	input  wire logic                          hf_variant_in,
	// sense codes
	input  wire logic [pfcms_pkg::SENSE_W-1:0] line_in,
	input  wire logic [pfcms_pkg::SENSE_W-1:0] link_in,
	input  wire logic [pfcms_pkg::SENSE_W-1:0] output_power_in,
	input  wire logic                          half_line_start_in,
	input  wire logic                          zero_current_detect_in,
	// outputs
	output logic                               gate_drive_out,
	output logic [1:0]                         mode_out
);
	localparam int TW = pfcms_pkg::TW;
	localparam int SW = pfcms_pkg::SENSE_W;

	logic [SW-1:0]  line_s1_r, line_s2_r, line_s3_r, line_r;
	logic [SW-1:0]  link_s1_r, link_s2_r, link_s3_r, link_r;
	logic [SW-1:0]  pwr_s1_r, pwr_s2_r, pwr_s3_r, pwr_r;
	logic [2:0]     zc_s_r;
	logic [1:0]     hl_s_r;
	logic           hf_s1_r, hf_r;
	logic           zc_fall, hl_pulse;
	pfcms_pkg::pfcms_mode_e mode_r;
	logic           startup_r;
	logic           skip_r, burst_phase_r;
	logic [TW-1:0]  cnt_r, ton_r, pmin_r, ton_w, pmin_w;
	logic           on_r, gate_r;

	// two-stage synchronisers, plus a third word stage to compare each word with its last sample
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			line_s1_r <= '0;
			line_s2_r <= '0;
			line_s3_r <= '0;
			link_s1_r <= '0;
			link_s2_r <= '0;
			link_s3_r <= '0;
			pwr_s1_r  <= '0;
			pwr_s2_r  <= '0;
			pwr_s3_r  <= '0;
			zc_s_r    <= 3'h0;
			hl_s_r    <= 2'h0;
		end else begin
			line_s1_r <= line_in;
			line_s2_r <= line_s1_r;
			line_s3_r <= line_s2_r;
			link_s1_r <= link_in;
			link_s2_r <= link_s1_r;
			link_s3_r <= link_s2_r;
			pwr_s1_r  <= output_power_in;
			pwr_s2_r  <= pwr_s1_r;
			pwr_s3_r  <= pwr_s2_r;
			zc_s_r    <= {zc_s_r[1:0], zero_current_detect_in};
			hl_s_r    <= {hl_s_r[0], half_line_start_in};
		end
	end

	// a word is taken only when two samples in a row agree, so a code caught mid-change is dropped
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			line_r <= '0;
			link_r <= '0;
			pwr_r  <= '0;
		end else begin
			if (line_s2_r == line_s3_r)
				line_r <= line_s2_r;
			if (link_s2_r == link_s3_r)
				link_r <= link_s2_r;
			if (pwr_s2_r == pwr_s3_r)
				pwr_r <= pwr_s2_r;
		end
	end

	logic hl_d_r;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in)
			hl_d_r <= 1'b0;
		else
			hl_d_r <= hl_s_r[1];
	end

	assign zc_fall = zc_s_r[2] & ~zc_s_r[1]; // R10
	assign hl_pulse = hl_s_r[1] & ~hl_d_r;

	// strap is a pin, so it passes two flops like the others
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			hf_s1_r <= 1'b0;
			hf_r    <= 1'b0;
		end else begin
			hf_s1_r <= hf_variant_in;
			hf_r    <= hf_s1_r;
		end
	end

	// startup hysteresis: enter below 90%, leave at 100%
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in)
			startup_r <= 1'b1; // R2
		else if (link_r < pfcms_pkg::STARTUP_CODE)
			startup_r <= 1'b1; // R1
		else if (link_r >= pfcms_pkg::EXIT_CODE)
			startup_r <= 1'b0; // R1
	end

	// burst skip decided at each half-line start, alternating whole half-lines
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			skip_r        <= 1'b0;
			burst_phase_r <= 1'b0;
		end else if (hl_pulse) begin
			if (!startup_r && pwr_r < pfcms_pkg::BURST_CODE) begin
				burst_phase_r <= ~burst_phase_r;
				skip_r        <= ~burst_phase_r; // R6
			end else begin
				burst_phase_r <= 1'b0;
				skip_r        <= 1'b0;
			end
		end
	end

	// mode register
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in)
			mode_r <= pfcms_pkg::PFCMS_STARTUP; // R2
		else if (startup_r)
			mode_r <= pfcms_pkg::PFCMS_STARTUP;
		else if (pwr_r < pfcms_pkg::BURST_CODE)
			mode_r <= pfcms_pkg::PFCMS_BURST;
		else
			mode_r <= pfcms_pkg::PFCMS_NORMAL;
	end

	pfcms_timing u_timing (
		.mode_in        (mode_r),
		.hf_variant_in  (hf_r),
		.line_in        (line_r),
		.link_in        (link_r),
		.power_in       (pwr_r),
		.ton_out        (ton_w),
		.period_min_out (pmin_w)
	);

	// switching cycle: on phase for ton, then off until zero-current fall and, outside startup, period floor met
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_r  <= '0;
			ton_r  <= pfcms_pkg::TON_MIN;
			pmin_r <= pfcms_pkg::PMIN_STD;
			on_r   <= 1'b0;
		end else if (skip_r) begin
			on_r  <= 1'b0; // R13
			cnt_r <= pmin_r;
		end else if (on_r) begin
			cnt_r <= cnt_r + TW'(1);
			if (cnt_r + TW'(1) >= ton_r)
				on_r <= 1'b0;
		end else begin
			if (cnt_r != '1)
				cnt_r <= cnt_r + TW'(1);
			// startup restarts at first valley (critical); otherwise wait for floor
			if (zc_fall && (startup_r || cnt_r >= pmin_r)) begin // R4 R5 R9 R10 R8
				on_r   <= 1'b1;
				cnt_r  <= '0;
				ton_r  <= ton_w;
				pmin_r <= startup_r ? pfcms_pkg::PMIN_STD : pmin_w; // R7 R4
			end
		end
	end

	// registered outputs
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			gate_r <= 1'b0;
		end else begin
			gate_r <= on_r & ~skip_r; // R13
		end
	end

	assign gate_drive_out = gate_r;
	assign mode_out       = mode_r;

	// checks
	gate_low_skip_a: assert property (@(posedge clk_in) disable iff (rst_in)
		$past(skip_r) |-> !gate_drive_out) else $error("gate high in burst skip"); // R13
	startup_enter_a: assert property (@(posedge clk_in) disable iff (rst_in)
		link_r < pfcms_pkg::STARTUP_CODE |=> startup_r) else $error("startup not entered"); // R1
	startup_exit_a: assert property (@(posedge clk_in) disable iff (rst_in)
		link_r >= pfcms_pkg::EXIT_CODE |=> !startup_r) else $error("startup not left"); // R1
	cycle_start_a: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(on_r) |-> $past(zc_fall)) else $error("cycle without zero-current fall"); // R10
	ton_len_a: assert property (@(posedge clk_in) disable iff (rst_in)
		on_r |-> cnt_r < ton_r) else $error("on-time overrun"); // R3
	period_cap_a: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(on_r) && !$past(startup_r) |-> $past(cnt_r) >= $past(pmin_r)) else $error("freq cap"); // R8
	burst_mode_a: assert property (@(posedge clk_in) disable iff (rst_in)
		!startup_r && pwr_r < pfcms_pkg::BURST_CODE |=> mode_r == pfcms_pkg::PFCMS_BURST)
		else $error("burst mode not selected"); // R6
	gate_follow_a: assert property (@(posedge clk_in) disable iff (rst_in)
		gate_drive_out |-> $past(on_r)) else $error("gate without on phase"); // R13

	cover_startup_c: cover property (@(posedge clk_in) disable iff (rst_in) $fell(startup_r));
	cover_burst_c: cover property (@(posedge clk_in) disable iff (rst_in) $rose(skip_r));
	cover_cycle_c: cover property (@(posedge clk_in) disable iff (rst_in) $fell(gate_drive_out));
endmodule : pfcms_top
`default_nettype wire

// file: pkg/pfcms_pkg.sv
// pfcms_pkg: constants and types for the pfc mode sequencer
// assumes sense inputs arrive as unsigned 16-bit codes where full scale equals nominal * 2
package pfcms_pkg;
	// sense code width; code 16'h8000 means 100% of nominal
	localparam int                    SENSE_W       = 16;
	localparam logic [SENSE_W-1:0]    NOMINAL_CODE  = 16'h8000;
	// startup entry at 90% and exit at 100% of nominal link voltage
	localparam int                    STARTUP_PCT   = 90;
	localparam int                    EXIT_PCT      = 100;
	localparam logic [SENSE_W-1:0]    STARTUP_CODE  = SENSE_W'(32768 * STARTUP_PCT / 100);
	localparam logic [SENSE_W-1:0]    EXIT_CODE     = SENSE_W'(32768 * EXIT_PCT / 100);
	// burst below 5% of nominal power
	localparam int                    BURST_PCT     = 5;
	localparam logic [SENSE_W-1:0]    BURST_CODE    = SENSE_W'(32768 * BURST_PCT / 100);
	// efficiency assumed by the power estimate, in percent
	localparam int                    EFF_PCT       = 100;
	// clock and frequency caps
	localparam int                    CLK_KHZ       = 250000;
	localparam int                    FMAX_STD_KHZ  = 70;
	localparam int                    FMAX_HF_KHZ   = 100;
	// shortest period in cycles, rounded up so the cap is never exceeded
	localparam int                    TW            = 16;
	localparam logic [TW-1:0]         PMIN_STD      = TW'((CLK_KHZ + FMAX_STD_KHZ - 1) / FMAX_STD_KHZ);
	localparam logic [TW-1:0]         PMIN_HF       = TW'((CLK_KHZ + FMAX_HF_KHZ - 1) / FMAX_HF_KHZ);
	// on-time bounds in cycles
	localparam logic [TW-1:0]         TON_MIN       = 16'h0010;
	localparam logic [TW-1:0]         TON_MAX       = 16'h0c00;
	// operating modes
	typedef enum logic [1:0] {PFCMS_STARTUP, PFCMS_NORMAL, PFCMS_BURST} pfcms_mode_e;
endpackage : pfcms_pkg

// file: hdl/pfcms_timing.sv
// pfcms_timing: computes on-time and minimum period for one switching cycle
// assumes inputs are stable codes sampled by the sequencer
`timescale 1ns/1ns
`default_nettype none
module pfcms_timing (
	// mode and variant
	input  wire logic [1:0]                   mode_in,
	input  wire logic                         hf_variant_in,
	// sense values
	input  wire logic [pfcms_pkg::SENSE_W-1:0] line_in,
	input  wire logic [pfcms_pkg::SENSE_W-1:0] link_in,
	input  wire logic [pfcms_pkg::SENSE_W-1:0] power_in,
	// results
	output logic      [pfcms_pkg::TW-1:0]      ton_out,
	output logic      [pfcms_pkg::TW-1:0]      period_min_out
);
	localparam int TW = pfcms_pkg::TW;

	logic [47:0] prod;
	logic [31:0] ratio;
	logic [pfcms_pkg::TW-1:0] pcap;

	// clamp helper for on-time
	function automatic logic [pfcms_pkg::TW-1:0] clamp_ton(input logic [31:0] v);
		if (v < 32'(pfcms_pkg::TON_MIN))
			return pfcms_pkg::TON_MIN;
		else if (v > 32'(pfcms_pkg::TON_MAX))
			return pfcms_pkg::TON_MAX;
		else
			return v[pfcms_pkg::TW-1:0];
	endfunction : clamp_ton

	// on-time: startup fixed peak current gives ton ~ 1/line; otherwise power-modulated
	always_comb begin
		// 48 bits: full-scale power times the on-time ceiling times 100 overflows 32
		prod = 48'(pfcms_pkg::TON_MAX) * 48'(power_in) * 48'(pfcms_pkg::EFF_PCT) / 48'd100;
		ratio = 32'd0;
		if (mode_in == 2'(pfcms_pkg::PFCMS_STARTUP)) begin
			ratio = (32'(pfcms_pkg::TON_MIN) << 15) / (32'(line_in) + 32'd1); // R3
			ton_out = clamp_ton(ratio << 4); // R3
		end else begin
			ton_out = clamp_ton(32'(prod >> 15)); // R11 R12
		end
	end

	// period floor: frequency cap, stretched near low line for trough-to-peak variation
	always_comb begin
		pcap = hf_variant_in ? pfcms_pkg::PMIN_HF : pfcms_pkg::PMIN_STD; // R8
		// boundary off-time: toff = ton*vin/(vlink-vin) kept via zero-current edge; floor grows at trough
		if (link_in > line_in)
			period_min_out = pcap + TW'({1'b0, ~line_in[15:1]} >> 4); // R7 R4
		else
			period_min_out = pcap;
	end

endmodule : pfcms_timing
`default_nettype wire

// file: tb/pfcms_stage_model.sv
// pfcms_stage_model: boost stage seen from the gate and the zero-current pin
// assumes gate is sampled on the controller clock; demag_in sets demagnetisation time
`timescale 1ns/1ns
`default_nettype none
module pfcms_stage_model (
	// clock and gate
	input  wire logic        clk_in,
	input  wire logic        gate_in,
	input  wire logic [15:0] demag_in,
	// winding comparator
	output logic             zc_out
);
	logic [15:0] cnt_r;

	// idle winding rings, so a free-running valley train is present at power-up
	initial begin
		cnt_r = 16'h0000;
		zc_out = 1'b1;
	end

	// high while energised, then each ring period gives one falling edge
	always @(posedge clk_in) begin
		if (gate_in) begin
			cnt_r <= 16'h0000;
			zc_out <= #1 1'b1;
		end else if (cnt_r < demag_in) begin
			cnt_r <= cnt_r + 16'h0001;
		end else begin
			cnt_r <= demag_in - 16'h0008; // ring half period of nine cycles
			zc_out <= #1 ~zc_out;
		end
	end
endmodule : pfcms_stage_model
`default_nettype wire

// file: tb/pfc_mode_sequencer_test.sv
// pfc_mode_sequencer_test: self-checking bench for the pfc mode sequencer
// assumes the stage model answers each gate pulse with a ringing zero-current pin
`timescale 1ns/1ns
`default_nettype none
module pfc_mode_sequencer_test;
	logic        clk, rst, hf, hls, gate;
	logic [15:0] line, link, pwr, demag;
	logic [1:0]  mode;
	wire logic   zc;
	int          err_total = 0;
	int          checks_done = 0;
	int          cyc = 0;

	pfcms_top DUT (.clk_in(clk), .rst_in(rst), .hf_variant_in(hf), .line_in(line),
		.link_in(link), .output_power_in(pwr), .half_line_start_in(hls),
		.zero_current_detect_in(zc), .gate_drive_out(gate), .mode_out(mode));
	pfcms_stage_model stage (.clk_in(clk), .gate_in(gate), .demag_in(demag), .zc_out(zc));

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			fail("cycle limit reached");
			results();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic fail(input string m);
		err_total++;
		$display("Error at %0t: %s", $time, m);
	endtask : fail

	// cycles until the next gate rising edge, bounded
	task automatic rise(output int n);
		logic p;
		n = 1;
		p = gate;
		tick(1);
		while (!(gate && !p) && n < 20000) begin
			p = gate;
			tick(1);
			n++;
		end
	endtask : rise

	task automatic step(input logic [15:0] v, input logic [1:0] m);
		link = v;
		tick(8);
		checks_done++;
		if (mode !== m) fail("wrong mode after link change");
	endtask : step

	task automatic t_reset;
		tick(5);
		checks_done += 2;
		if (gate !== 1'b0) fail("gate high in reset");
		if (mode !== 2'h0) fail("not startup in reset");
		rst = 1'b0;
		tick(3);
		checks_done++;
		if (mode !== 2'h0) fail("not startup after reset");
		$display("reset test done");
	endtask : t_reset

	task automatic t_startup;
		int n, n1, a;
		@(negedge zc);
		n = 0;
		while (gate !== 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
		checks_done++;
		if (n < 4 || n > 6) fail("valley did not start a cycle");
		n = 0;
		while (gate === 1'b1 && n < 5000) begin
			tick(1);
			n++;
		end
		checks_done++;
		if (n < pfcms_pkg::TON_MIN || n > pfcms_pkg::TON_MAX) fail("on-time out of range");
		// constant peak current: halving the line voltage doubles the on-time
		n1 = n;
		line = 16'h3000;
		rise(a);
		n = 0;
		while (gate === 1'b1 && n < 5000) begin
			tick(1);
			n++;
		end
		line = 16'h6000;
		checks_done++;
		if (n < 2 * n1 - 32 || n > 2 * n1 + 32) fail("startup peak current not constant");
		$display("startup test done");
	endtask : t_startup

	task automatic t_cap(input logic v, input logic [15:0] d);
		int a, b, n, e;
		hf = v;
		demag = d;
		rise(a);
		rise(b);
		checks_done += 2;
		if (b < (v ? pfcms_pkg::PMIN_HF : pfcms_pkg::PMIN_STD)) fail("period under floor");
		if (b >= 20000) fail("no restart after valley");
		// normal on-time scales with power at full efficiency
		n = 0;
		while (gate === 1'b1 && n < 5000) begin
			tick(1);
			n++;
		end
		e = int'(pfcms_pkg::TON_MAX) * int'(pwr) / int'(pfcms_pkg::NOMINAL_CODE);
		checks_done++;
		if (n != e) fail("on-time not proportional to power");
		$display("frequency cap test done");
	endtask : t_cap

	task automatic t_burst;
		int c[2];
		logic p;
		pwr = pfcms_pkg::BURST_CODE - 16'h0001;
		tick(8);
		checks_done++;
		if (mode !== 2'h2) fail("no burst at light load");
		for (int h = 0; h < 2; h++) begin
			hls = 1'b1;
			tick(4);
			hls = 1'b0;
			c[h] = 0;
			p = gate;
			repeat (8000) begin
				tick(1);
				if (gate && !p) c[h]++;
				p = gate;
			end
		end
		checks_done++;
		if ((c[0] == 0) == (c[1] == 0)) fail("half-lines not skipped alternately");
		pwr = pfcms_pkg::BURST_CODE;
		tick(8);
		checks_done++;
		if (mode !== 2'h1) fail("burst kept at threshold power");
		$display("burst test done");
	endtask : t_burst

	task automatic results;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results

	// main sequence
	initial begin
		rst = 1'b1;
		hf = 1'b0;
		hls = 1'b0;
		line = 16'h6000;
		link = 16'h0000;
		pwr = 16'h4000;
		demag = 16'h0028;
		t_reset();
		t_startup();
		step(pfcms_pkg::EXIT_CODE - 16'h0001, 2'h0);
		step(pfcms_pkg::EXIT_CODE, 2'h1);
		step(pfcms_pkg::STARTUP_CODE, 2'h1);
		step(pfcms_pkg::STARTUP_CODE - 16'h0001, 2'h0);
		step(pfcms_pkg::EXIT_CODE, 2'h1);
		$display("mode test done");
		t_cap(1'b0, 16'h0028);
		t_cap(1'b1, 16'h0258);
		t_burst();
		results();
	end
endmodule : pfc_mode_sequencer_test
`default_nettype wire
